/* hw/adc_control_pkg.sv */
// Purpose: Shared constants and types for the converter control block
// Assumes: 8-bit special-function-register bus with 8-bit addresses
// Notes:   Offsets are byte addresses on that bus
package adc_control_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'hA1;
	localparam logic [7:0] ADDR_RESULT_HIGH       = 8'hA2;
	localparam logic [7:0] ADDR_RESULT_LOW_FLAGS  = 8'hA3;
	localparam logic [7:0] ADDR_STATIC_CONFIG     = 8'hA4;

	// Reset values
	localparam logic [7:0] RESET_CONVERTER_CONTROL = 8'h80;
	localparam logic [7:0] RESET_STATIC_CONFIG     = 8'h0A;

	// Control register field positions
	localparam int CTRL_START_TOGGLE_BIT = 7;
	localparam int CTRL_CONTINUOUS_BIT   = 6;
	localparam int CTRL_POWERED_BIT      = 5;
	localparam int CTRL_EXT_REF_BIT      = 4;
	localparam int CTRL_INPUT_SEL_MSB    = 3;

	// Static configuration field positions
	localparam int STAT_DIFFERENTIAL_BIT = 7;
	localparam int STAT_SLEEP_BIT        = 6;
	localparam int STAT_FAST_DIV_BIT     = 5;
	localparam int STAT_BIAS_MSB         = 4;
	localparam int STAT_BIAS_LSB         = 2;
	localparam int STAT_RES_MSB          = 1;

	// Low result register flag positions
	localparam int LOW_UNDERFLOW_BIT = 2;
	localparam int LOW_OVERFLOW_BIT  = 1;
	localparam int LOW_RANGE_BIT     = 0;

	// Input select code that routes one third of the supply
	localparam logic [3:0] INPUT_SUPPLY_THIRD = 4'h8;

	// Resolution codes
	localparam logic [1:0] RES_6_BIT  = 2'h0;
	localparam logic [1:0] RES_8_BIT  = 2'h1;
	localparam logic [1:0] RES_10_BIT = 2'h2;
	localparam logic [1:0] RES_12_BIT = 2'h3;

	// Converter clock division ratios
	localparam int         DIV_SLOW_RATIO = 32;
	localparam int         DIV_FAST_RATIO = 8;
	localparam logic [4:0] DIV_SLOW_LAST  = 5'(DIV_SLOW_RATIO - 1);
	localparam logic [4:0] DIV_FAST_LAST  = 5'(DIV_FAST_RATIO - 1);

	// Conversion step counts: the N/2 bit steps at 6 bits, and the extra steps beyond N/2
	localparam logic [3:0] HALF_BITS_6    = 4'h3;
	localparam logic [3:0] SINGLE_EXTRA   = 4'h3;
	localparam logic [3:0] CONTINUE_EXTRA = 4'h1;

	// Settings passed to the analog core
	typedef struct packed {
		logic       powered;
		logic       sleep;
		logic       externalRef;
		logic       supplyThird;
		logic       differential;
		logic [3:0] inputSelect;
		logic [2:0] biasTrim;
		logic [1:0] resolution;
	} analog_ctrl_t;

	// Conversion sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b01,
		SEQ_CONVERT = 2'b10
	} seq_state_t;

endpackage : adc_control_pkg

/* hw/adc_control_interface.sv */
// Purpose: Register file and conversion sequencer for the multi-input converter
// Assumes: Core returns two decided bits per converter clock and range flags at the end
// Notes:   Operation
// Operation
// - Two-bit resolution field picks 6, 8, 10 or 12 bits; result fills high then low.
// - Reset leaves resolution at 10 bits.
// - Start toggle high-low-high starts single conversion; synchronised; ignored when continuous.
// - Continuous bit makes converter run repeatedly; start toggle has no effect.
// - Clearing power bit powers down the whole subsystem; setting powers it up.
// - Reference bit: 0 internal bandgap, 1 external pin; ignored when input is 8.
// - Input select 0-7 routes that input; 8 routes supply third with bandgap.
// - Differential bit: input zero inverting, selected input 1-7 noninverting.
// - Sleep bit gives reduced-power mode while subsystem stays powered.
// - Divider bit: 0 gives CPU clock over 32, 1 gives over 8.
// - Three bias trim bits are passed straight to the converter core.
// - Two result bits resolved per converter clock cycle.
// - High result holds eight top bits; top two read zero at 6 bits.
// - Low result bits 7-4 hold left-justified low bits; unused read zero.
// - Underflow sets low bit 2 and forces result to all zeros.
// - Overflow without underflow sets low bit 1 and forces result to all ones.
// - Low bit 0 is underflow OR overflow; low bit 3 reads zero.
// - Control register resets to 0x80.
// - Static configuration register resets to 0x0A.
// - Every completed conversion raises the end-of-conversion event.
// - Single conversion starts on first converter edge; result N/2+3 clocks later.
// - A new start during a single conversion abandons it and restarts.
// - Continuous conversions are spaced N/2+1 converter clocks apart.
`timescale 1ns/1ps

module adc_control_interface
	import adc_control_pkg::*;
(
	// Clock and reset
	input  wire  logic         core_clk,
	input  wire  logic         srst,
	// Special-function-register bus
	input  wire  logic [7:0]   sfrAddr,
	input  wire  logic         sfrWrite,
	input  wire  logic         sfrRead,
	input  wire  logic [7:0]   sfrWriteData,
	output       logic [7:0]   sfrReadData,
	// Analog core control
	output       analog_ctrl_t analogCtrl,
	output       logic         converterClock,
	output       logic         sampleStrobe,
	// Analog core answers
	input  wire  logic [1:0]   coreBits,
	input  wire  logic         coreUnderflow,
	input  wire  logic         coreOverflow,
	// Event to the interrupt controller
	output       logic         conversionDone
);

	logic [7:0]  converterControl;
	logic [7:0]  converterStaticConfig;
	logic [7:0]  resultHigh;
	logic [7:0]  resultLowAndFlags;
	logic [4:0]  divCount;
	logic        convTick;
	logic        startSync1;
	logic        startSync2;
	logic        startSync3;
	seq_state_t  seqState;
	logic [3:0]  stepCount;
	logic [11:0] bitShift;
	logic [1:0]  convResolution;

	logic        continuousRun;
	logic        converterPowered;
	logic [3:0]  inputSelect;
	logic [1:0]  resolutionSelect;
	logic        fastClockDivSelect;
	logic [4:0]  divLast;
	logic        startRequest;
	logic        beginConversion;
	logic [3:0]  halfBits;
	logic [3:0]  stepLimit;
	logic        finishTick;
	logic [11:0] rawValue;
	logic [11:0] fullScale;
	logic [11:0] finalValue;
	logic [7:0]  next_resultHigh;
	logic [7:0]  next_resultLow;

	assign continuousRun      = converterControl[CTRL_CONTINUOUS_BIT];
	assign converterPowered   = converterControl[CTRL_POWERED_BIT];
	assign inputSelect        = converterControl[CTRL_INPUT_SEL_MSB:0];
	assign resolutionSelect   = converterStaticConfig[STAT_RES_MSB:0];
	assign fastClockDivSelect = converterStaticConfig[STAT_FAST_DIV_BIT];

	// Control register, written by software
	always_ff @(posedge core_clk) begin
		if (srst) begin
			converterControl <= RESET_CONVERTER_CONTROL;
		end else if (sfrWrite && sfrAddr == ADDR_CONVERTER_CONTROL) begin
			converterControl <= sfrWriteData;
		end
	end

	// Static configuration register, written by software
	always_ff @(posedge core_clk) begin
		if (srst) begin
			converterStaticConfig <= RESET_STATIC_CONFIG;
		end else if (sfrWrite && sfrAddr == ADDR_STATIC_CONFIG) begin
			converterStaticConfig <= sfrWriteData;
		end
	end

	// Register read port
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sfrReadData <= 8'h00;
		end else if (sfrRead) begin
			unique case (sfrAddr)
				ADDR_CONVERTER_CONTROL: sfrReadData <= converterControl;
				ADDR_RESULT_HIGH:       sfrReadData <= resultHigh;
				ADDR_RESULT_LOW_FLAGS:  sfrReadData <= resultLowAndFlags;
				ADDR_STATIC_CONFIG:     sfrReadData <= converterStaticConfig;
				default:                sfrReadData <= 8'h00;
			endcase
		end
	end

	// Settings towards the analog core
	always_ff @(posedge core_clk) begin
		if (srst) begin
			analogCtrl <= '0;
		end else begin
			analogCtrl.powered      <= converterPowered;
			analogCtrl.sleep        <= converterStaticConfig[STAT_SLEEP_BIT];
			analogCtrl.supplyThird  <= (inputSelect == INPUT_SUPPLY_THIRD);
			analogCtrl.externalRef  <= converterControl[CTRL_EXT_REF_BIT]
				&& (inputSelect != INPUT_SUPPLY_THIRD);
			analogCtrl.differential <= converterStaticConfig[STAT_DIFFERENTIAL_BIT];
			analogCtrl.inputSelect  <= inputSelect;
			analogCtrl.biasTrim     <= converterStaticConfig[STAT_BIAS_MSB:STAT_BIAS_LSB];
			analogCtrl.resolution   <= resolutionSelect;
		end
	end

	// Converter clock divider, stopped while powered down
	assign divLast = fastClockDivSelect ? DIV_FAST_LAST : DIV_SLOW_LAST;

	always_ff @(posedge core_clk) begin
		if (srst || !converterPowered) begin
			divCount <= 5'h00;
		end else if (divCount >= divLast) begin
			divCount <= 5'h00;
		end else begin
			divCount <= divCount + 5'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || !converterPowered) begin
			convTick       <= 1'b0;
			converterClock <= 1'b0;
		end else begin
			convTick       <= (divCount >= divLast);
			converterClock <= (divCount < {1'b0, divLast[4:1]}) || (divCount >= divLast);
		end
	end

	// Start toggle brought into the converter clock domain
	always_ff @(posedge core_clk) begin
		if (srst) begin
			startSync1 <= 1'b1;
			startSync2 <= 1'b1;
			startSync3 <= 1'b1;
		end else if (convTick) begin
			startSync1 <= converterControl[CTRL_START_TOGGLE_BIT];
			startSync2 <= startSync1;
			startSync3 <= startSync2;
		end
	end

	assign startRequest    = startSync2 && !startSync3 && !continuousRun;
	assign beginConversion = convTick && converterPowered
		&& (startRequest || (continuousRun && seqState == SEQ_IDLE));

	// Step counts for the resolution latched at start
	assign halfBits   = HALF_BITS_6 + {2'b00, convResolution};
	assign stepLimit  = halfBits + (continuousRun ? CONTINUE_EXTRA : SINGLE_EXTRA);
	assign finishTick = convTick && seqState == SEQ_CONVERT && stepCount >= stepLimit;

	// Conversion sequencer
	always_ff @(posedge core_clk) begin
		if (srst || !converterPowered) begin
			seqState <= SEQ_IDLE;
		end else if (beginConversion) begin
			seqState <= SEQ_CONVERT;
		end else if (finishTick && !continuousRun) begin
			seqState <= SEQ_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stepCount <= 4'h0;
		end else if (beginConversion || (finishTick && continuousRun)) begin
			stepCount <= 4'h1;
		end else if (convTick && seqState == SEQ_CONVERT) begin
			stepCount <= stepCount + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			convResolution <= RES_10_BIT;
		end else if (beginConversion || (finishTick && continuousRun)) begin
			convResolution <= resolutionSelect;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sampleStrobe <= 1'b0;
		end else begin
			sampleStrobe <= beginConversion || (finishTick && continuousRun);
		end
	end

	// Two decided bits shifted in per converter clock
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bitShift <= 12'h000;
		end else if (beginConversion || (finishTick && continuousRun)) begin
			bitShift <= 12'h000;
		end else if (convTick && seqState == SEQ_CONVERT && stepCount <= halfBits) begin
			bitShift <= {bitShift[9:0], coreBits};
		end
	end

	// Result value with range handling
	always_comb begin
		unique case (convResolution)
			RES_6_BIT:  fullScale = 12'h03F;
			RES_8_BIT:  fullScale = 12'h0FF;
			RES_10_BIT: fullScale = 12'h3FF;
			RES_12_BIT: fullScale = 12'hFFF;
		endcase
		rawValue = bitShift & fullScale;
		if (coreUnderflow) begin
			finalValue = 12'h000;
		end else if (coreOverflow) begin
			finalValue = fullScale;
		end else begin
			finalValue = rawValue;
		end
	end

	// Result alignment into high and low registers
	always_comb begin
		next_resultHigh = 8'h00;
		next_resultLow  = 8'h00;
		unique case (convResolution)
			RES_6_BIT: begin
				next_resultHigh = {2'b00, finalValue[5:0]};
			end
			RES_8_BIT: begin
				next_resultHigh = finalValue[7:0];
			end
			RES_10_BIT: begin
				next_resultHigh = finalValue[9:2];
				next_resultLow  = {finalValue[1:0], 6'b000000};
			end
			RES_12_BIT: begin
				next_resultHigh = finalValue[11:4];
				next_resultLow  = {finalValue[3:0], 4'h0};
			end
		endcase
		next_resultLow[LOW_UNDERFLOW_BIT] = coreUnderflow;
		next_resultLow[LOW_OVERFLOW_BIT]  = coreOverflow && !coreUnderflow;
		next_resultLow[LOW_RANGE_BIT]     = coreUnderflow || coreOverflow;
	end

	// Result registers, updated together at completion
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resultHigh        <= 8'h00;
			resultLowAndFlags <= 8'h00;
		end else if (finishTick) begin
			resultHigh        <= next_resultHigh;
			resultLowAndFlags <= next_resultLow;
		end
	end

	// End-of-conversion event
	always_ff @(posedge core_clk) begin
		if (srst) begin
			conversionDone <= 1'b0;
		end else begin
			conversionDone <= finishTick;
		end
	end

endmodule : adc_control_interface

/* tb/adc_core_model.sv */
// Purpose: Behavioural analog core answering the converter control block
// Assumes: Bench sets the bit pair and range flags the core reports
// Notes:   Outputs toggle every cycle while the subsystem is powered down
`timescale 1ns/1ps

module adc_core_model
	import adc_control_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         srst,
	// Settings from the block
	input  wire analog_ctrl_t analogCtrl,
	// Bench controls
	input  wire logic [1:0]   pairSet,
	input  wire logic         underSet,
	input  wire logic         overSet,
	// Core answers
	output      logic [1:0]   coreBits,
	output      logic         coreUnderflow,
	output      logic         coreOverflow
);
	logic [1:0] junk;

	always_ff @(posedge core_clk) begin
		if (srst)
			junk <= 2'h1;
		else
			junk <= ~junk;
	end

	// Two decided bits per converter clock, meaningless while powered down
	assign coreBits      = analogCtrl.powered ? pairSet : junk;
	assign coreUnderflow = analogCtrl.powered ? underSet : junk[0];
	assign coreOverflow  = analogCtrl.powered ? overSet : junk[1];
endmodule : adc_core_model

/* tb/adc_control_checker.sv */
// Purpose: Port-level assertions for the converter control block
// Assumes: Resolution is unchanged while a conversion runs
// Notes:   Converter clock rises are counted from each sample strobe
`timescale 1ns/1ps

module adc_control_checker
	import adc_control_pkg::*;
(
	// Clock and reset
	input wire logic         core_clk,
	input wire logic         srst,
	// Register bus
	input wire logic [7:0]   sfrAddr,
	input wire logic         sfrWrite,
	input wire logic         sfrRead,
	input wire logic [7:0]   sfrWriteData,
	input wire logic [7:0]   sfrReadData,
	// Core side
	input wire analog_ctrl_t analogCtrl,
	input wire logic         converterClock,
	input wire logic         sampleStrobe,
	input wire logic [1:0]   coreBits,
	input wire logic         coreUnderflow,
	input wire logic         coreOverflow,
	input wire logic         conversionDone
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic [3:0] ticks;
	logic [3:0] res;

	assign res = 4'(analogCtrl.resolution);

	always_ff @(posedge core_clk) begin
		if (srst || sampleStrobe)
			ticks <= 4'h0;
		else if ($rose(converterClock) && ticks != 4'hF)
			ticks <= ticks + 4'h1;
	end

	sequence s_low_read;
		sfrRead && sfrAddr == ADDR_RESULT_LOW_FLAGS;
	endsequence
	sequence s_single_end;
		conversionDone && !sampleStrobe;
	endsequence
	sequence s_cycle_end;
		conversionDone && sampleStrobe;
	endsequence

	a_reset_values: assert property (
		$fell(srst) |-> ##2 analogCtrl.resolution == RES_10_BIT && !analogCtrl.powered)
		else $error("bad settings after reset");
	a_done_pulse: assert property (conversionDone |=> !conversionDone)
		else $error("done longer than one cycle");
	a_strobe_pulse: assert property (sampleStrobe |=> !sampleStrobe)
		else $error("strobe longer than one cycle");
	a_supply_third: assert property (
		analogCtrl.supplyThird == (analogCtrl.inputSelect == INPUT_SUPPLY_THIRD))
		else $error("supply third mismatch");
	a_ref_forced: assert property (analogCtrl.supplyThird |-> !analogCtrl.externalRef)
		else $error("external reference with supply input");
	a_clock_off: assert property (
		!analogCtrl.powered && !$past(analogCtrl.powered) |-> !converterClock)
		else $error("converter clock runs while powered down");
	a_range_or: assert property (s_low_read |=> sfrReadData[0] == (sfrReadData[2] | sfrReadData[1])
		&& !sfrReadData[3] && !(sfrReadData[2] && sfrReadData[1]))
		else $error("range flags inconsistent");
	a_single_len: assert property (
		s_single_end |-> ticks == res + 4'h6)
		else $error("single conversion length wrong");
	a_cycle_len: assert property (
		s_cycle_end |-> ticks == res + 4'h4)
		else $error("continuous spacing wrong");
endmodule : adc_control_checker

bind adc_control_interface adc_control_checker u_checker (
	.core_clk(core_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
	.sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData), .analogCtrl(analogCtrl),
	.converterClock(converterClock), .sampleStrobe(sampleStrobe), .coreBits(coreBits),
	.coreUnderflow(coreUnderflow), .coreOverflow(coreOverflow), .conversionDone(conversionDone));

/* tb/adc_control_interface_tb.sv */
// Purpose: Register-level tests of the converter control block
// Assumes: Core model reports the bit pair 10 on every step
// Notes:   Results without range flags are expected patterns of repeated 10 pairs
`timescale 1ns/1ps

module adc_control_interface_tb
	import adc_control_pkg::*;
;
	logic         core_clk, srst, sfrWrite, sfrRead, underSet, overSet;
	logic [7:0]   sfrAddr, sfrWriteData, sfrReadData, d;
	logic [1:0]   pairSet, coreBits;
	logic         coreUnderflow, coreOverflow, converterClock, sampleStrobe, conversionDone;
	analog_ctrl_t analogCtrl;
	int           fails, nChecks, n, r;
	logic [7:0]   hiExp [4] = '{8'h2A, 8'hAA, 8'hAA, 8'hAA};
	logic [7:0]   loExp [4] = '{8'h00, 8'h00, 8'h80, 8'hA0};
	logic [1:0]   flagSet [3] = '{2'h2, 2'h1, 2'h3};
	logic [7:0]   fHi [3] = '{8'h00, 8'hFF, 8'h00};
	logic [7:0]   fLo [3] = '{8'h05, 8'hC3, 8'h05};

	adc_control_interface u_dut (
		.core_clk(core_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
		.sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData), .analogCtrl(analogCtrl),
		.converterClock(converterClock), .sampleStrobe(sampleStrobe), .coreBits(coreBits),
		.coreUnderflow(coreUnderflow), .coreOverflow(coreOverflow), .conversionDone(conversionDone));
	adc_core_model u_core (
		.core_clk(core_clk), .srst(srst), .analogCtrl(analogCtrl), .pairSet(pairSet), .underSet(underSet),
		.overSet(overSet), .coreBits(coreBits), .coreUnderflow(coreUnderflow), .coreOverflow(coreOverflow));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		sfrAddr <= a;
		sfrWriteData <= v;
		sfrWrite <= 1'b1;
		@(posedge core_clk);
		sfrWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge core_clk);
		sfrRead <= 1'b0;
		#1;
		v = sfrReadData;
	endtask : rd

	// Cycles until the next rise of the done pulse or the converter clock
	task automatic span(input bit sel, output int k);
		logic p, s;
		p = 1'b1;
		for (k = 1; k < 3000; k++) begin
			@(posedge core_clk);
			#1;
			s = sel ? converterClock : conversionDone;
			if (s === 1'b1 && p === 1'b0)
				return;
			p = s;
		end
		fails++;
		wrap_up();
	endtask : span

	task automatic start_conv();
		wr(ADDR_CONVERTER_CONTROL, 8'h20);
		repeat (30) @(posedge core_clk);
		wr(ADDR_CONVERTER_CONTROL, 8'hA0);
	endtask : start_conv

	initial begin
		{sfrAddr, sfrWriteData, sfrWrite, sfrRead, underSet, overSet} = '0;
		pairSet = 2'h2;
		srst = 1'b1;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(ADDR_CONVERTER_CONTROL, d);
		chk(16'(d), 16'h0080);
		rd(ADDR_STATIC_CONFIG, d);
		chk(16'(d), 16'h000A);
		wr(ADDR_RESULT_HIGH, 8'h55);
		rd(ADDR_RESULT_HIGH, d);
		chk(16'(d), 16'h0000);
		rd(8'hA5, d);
		chk(16'(d), 16'h0000);
		$display("test reset values done");
		wr(ADDR_CONVERTER_CONTROL, 8'hB8);
		wr(ADDR_STATIC_CONFIG, 8'hDF);
		repeat (3) @(posedge core_clk);
		chk(16'(analogCtrl), 16'(analog_ctrl_t'{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'h8, 3'h7, 2'h3}));
		wr(ADDR_CONVERTER_CONTROL, 8'hB3);
		repeat (3) @(posedge core_clk);
		chk(16'(analogCtrl), 16'(analog_ctrl_t'{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h3, 3'h7, 2'h3}));
		wr(ADDR_CONVERTER_CONTROL, 8'h80);
		repeat (40) @(posedge core_clk);
		chk(16'({analogCtrl.powered, converterClock}), 16'h0000);
		$display("test settings done");
		wr(ADDR_CONVERTER_CONTROL, 8'hA0);
		for (r = 0; r < 4; r++) begin
			wr(ADDR_STATIC_CONFIG, 8'h28 | 8'(r));
			start_conv();
			span(1'b0, n);
			rd(ADDR_RESULT_HIGH, d);
			chk(16'(d), 16'(hiExp[r]));
			rd(ADDR_RESULT_LOW_FLAGS, d);
			chk(16'(d), 16'(loExp[r]));
		end
		$display("test resolutions done");
		wr(ADDR_STATIC_CONFIG, 8'h2A);
		for (r = 0; r < 3; r++) begin
			@(posedge core_clk);
			{underSet, overSet} <= flagSet[r];
			start_conv();
			span(1'b0, n);
			rd(ADDR_RESULT_HIGH, d);
			chk(16'(d), 16'(fHi[r]));
			rd(ADDR_RESULT_LOW_FLAGS, d);
			chk(16'(d), 16'(fLo[r]));
		end
		@(posedge core_clk);
		{underSet, overSet} <= 2'h0;
		$display("test range flags done");
		wr(ADDR_STATIC_CONFIG, 8'h2B);
		start_conv();
		repeat (10) @(posedge core_clk);
		start_conv();
		span(1'b0, n);
		chk(16'(n > 70), 16'h0001);
		$display("test abort done");
		for (r = 0; r < 2; r++) begin
			wr(ADDR_STATIC_CONFIG, r ? 8'h0A : 8'h2A);
			wr(ADDR_CONVERTER_CONTROL, 8'hE0);
			span(1'b1, n);
			span(1'b1, n);
			chk(16'(n), r ? 16'h0020 : 16'h0008);
			span(1'b0, n);
			span(1'b0, n);
			chk(16'(n), r ? 16'h00C0 : 16'h0030);
			wr(ADDR_CONVERTER_CONTROL, 8'hA0);
			// Let the running conversion end before settings change
			span(1'b0, n);
		end
		$display("test continuous done");
		wrap_up();
	end
endmodule : adc_control_interface_tb
